// [rtl/pecu_regs.vh]
// Constants for the performance event counter unit: event codes, masks, sizes.
// Included by the counter unit; holds definitions only.
`ifndef PECU_REGS_VH
`define PECU_REGS_VH
`define PECU_CORE_CNT        4
`define PECU_UNC_CNT         8
`define PECU_CNT_W           48
`define PECU_CORE_N          4
`define PECU_LP_N            8
`define PECU_EVT_W           8
`define PECU_CMASK_W         8
// Core event codes and the alias unit mask
`define PECU_EV_DC_LOAD      8'h40
`define PECU_EV_DC_STORE     8'h41
`define PECU_EV_DC_LOCK      8'h42
`define PECU_EV_DC_ALLREF    8'h43
`define PECU_EV_DC_WB        8'h28
`define PECU_EV_ALIAS        8'h07
`define PECU_UM_ALIAS        8'h01
`define PECU_EV_LSD          8'ha8
`define PECU_EV_MSDEC        8'hd1
// Uncore event codes
`define PECU_EV_RT_OCC       8'h02
// Unit mask bits for coherence state (M,E,S,I), then the alias compare width
`define PECU_UM_I            0
`define PECU_UM_S            1
`define PECU_UM_E            2
`define PECU_UM_M            3
`define PECU_ALIAS_BITS      12
`endif

// [rtl/pecu_counter_unit.v]
// Core and uncore event counters with overflow interrupt routing.
// Assumes event inputs are one-cycle indications synchronous to sys_clk;
// the uncore clock domain's unhalted state arrives as a per-cycle level.
// Counters are 48 bits wide and wrap; overflow flags stay set until cleared.
// Uncore counters never see a core identity, so routing is by pattern only.
`timescale 1ns/10ps
`include "pecu_regs.vh"
module pecu_counter_unit (
  input  wire                                     sys_clk,
  input  wire                                     nrst,
  // Core counter configuration, packed per counter
  input  wire [`PECU_CORE_CNT*`PECU_EVT_W-1:0]    coreEvtCode,
  input  wire [`PECU_CORE_CNT*`PECU_EVT_W-1:0]    coreUnitMask,
  input  wire [`PECU_CORE_CNT*`PECU_CMASK_W-1:0]  coreCmask,
  input  wire [`PECU_CORE_CNT*3-1:0]              coreLpSel,
  input  wire [`PECU_CORE_CNT-1:0]                coreEnable,
  input  wire [`PECU_CORE_CNT-1:0]                coreOvfClr,
  // Core event sources
  input  wire                                     dcLoad,
  input  wire                                     dcStore,
  input  wire                                     dcLock,
  input  wire                                     dcCacheable,
  input  wire [3:0]                               dcState,
  input  wire                                     dcWriteback,
  input  wire [3:0]                               l2State,
  input  wire                                     storeFwdCheck,
  input  wire [`PECU_ALIAS_BITS-1:0]              loadAddrLow,
  input  wire [`PECU_ALIAS_BITS-1:0]              storeAddrLow,
  input  wire                                     addrFullMatch,
  input  wire [7:0]                               lsdActivity,
  input  wire                                     complexDecode,
  input  wire                                     fpAssist,
  // Uncore configuration
  input  wire [`PECU_UNC_CNT*`PECU_EVT_W-1:0]     uncEvtCode,
  input  wire [`PECU_UNC_CNT*`PECU_EVT_W-1:0]     uncUnitMask,
  input  wire [`PECU_UNC_CNT*`PECU_CMASK_W-1:0]   uncCmask,
  input  wire [`PECU_UNC_CNT-1:0]                 uncEnable,
  input  wire [`PECU_UNC_CNT:0]                   uncOvfClr,
  input  wire [`PECU_CORE_N-1:0]                  coreSelPattern,
  input  wire                                     fixedEnable,
  // Uncore event sources
  input  wire                                     uncoreUnhalted,
  input  wire [5:0]                               rtOccupancy,
  input  wire [3:0]                               rtStageValid,
  input  wire [7:0]                               uncEventBits,
  // Results
  output reg  [`PECU_CORE_CNT*`PECU_CNT_W-1:0]    coreCount,
  output reg  [`PECU_UNC_CNT*`PECU_CNT_W-1:0]     uncCount,
  output reg  [`PECU_CNT_W-1:0]                   fixedCount,
  output reg  [`PECU_CORE_CNT-1:0]                coreOvf,
  output reg  [`PECU_UNC_CNT:0]                   uncOvf,
  output reg  [`PECU_LP_N-1:0]                    lpPerfIrq,
  output reg  [`PECU_CORE_N-1:0]                  corePerfIrq
);

  // ==========================================================================
  // Shared event decode
  wire [3:0] dcStMask;
  wire       aliasHit;
  wire [7:0] lsdCount;
  wire       msDecode;
  wire       dcLoadRef;
  wire       dcStoreRef;
  wire       dcAnyRef;
  wire       lowBitsMatch;

  // State mask is one-hot; an I-state reference is a miss
  assign dcStMask = dcState;

  // Only cacheable loads and stores are split by state
  assign dcLoadRef  = dcLoad & dcCacheable;
  assign dcStoreRef = dcStore & dcCacheable;
  assign dcAnyRef   = dcLoad | dcStore;

  // Low-bit alias
  // A full match forwards properly, so it is no alias
  assign lowBitsMatch = (loadAddrLow == storeAddrLow);
  assign aliasHit     = storeFwdCheck & lowBitsMatch & ~addrFullMatch;

  // Activity is counted raw or through the threshold
  assign lsdCount = lsdActivity;

  assign msDecode = complexDecode | fpAssist;

  // ==========================================================================
  // Core counters
  genvar gi;
  generate
    for (gi = 0; gi < `PECU_CORE_CNT; gi = gi + 1) begin : gCore
      wire [`PECU_EVT_W-1:0]   code;
      wire [`PECU_EVT_W-1:0]   umask;
      wire [`PECU_CMASK_W-1:0] cm;
      reg  [7:0]               inc;
      reg                      dcEvt;
      wire [`PECU_CNT_W:0]     sum;
      assign code  = coreEvtCode[gi*`PECU_EVT_W +: `PECU_EVT_W];
      assign umask = coreUnitMask[gi*`PECU_EVT_W +: `PECU_EVT_W];
      assign cm    = coreCmask[gi*`PECU_CMASK_W +: `PECU_CMASK_W];

      always @* begin
        inc   = 8'h00;
        dcEvt = 1'b0;
        case (code)
          `PECU_EV_DC_LOAD: begin
            dcEvt = dcLoadRef & |(umask[3:0] & dcStMask);
          end
          `PECU_EV_DC_STORE: begin
            dcEvt = dcStoreRef & |(umask[3:0] & dcStMask);
          end
          `PECU_EV_DC_LOCK: begin
            dcEvt = dcLock & |(umask[3:1] & dcStMask[3:1]);
          end
          // Unit mask bit one widens to uncacheable references
          `PECU_EV_DC_ALLREF: begin
            dcEvt = dcAnyRef & (dcCacheable | umask[1]);
          end
          `PECU_EV_DC_WB: begin
            dcEvt = dcWriteback & |(umask[3:0] & l2State);
          end
          // Alias needs its exact unit mask
          `PECU_EV_ALIAS: begin
            inc = {7'h00, aliasHit & (umask == `PECU_UM_ALIAS)};
          end
          `PECU_EV_LSD: begin
            if (cm == 8'h00) begin
              inc = lsdCount;
            end else begin
              inc = {7'h00, lsdCount >= cm};
            end
          end
          `PECU_EV_MSDEC: begin
            inc = {7'h00, msDecode};
          end
          default: begin
            inc = 8'h00;
          end
        endcase
        // Cache events first two only
        // Counters two and three carry no cache event wiring
        if (dcEvt && (gi < 2)) begin
          inc = 8'h01;
        end
      end

      assign sum = {1'b0, coreCount[gi*`PECU_CNT_W +: `PECU_CNT_W]} + {41'h0, inc};

      always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
          coreCount[gi*`PECU_CNT_W +: `PECU_CNT_W] <= 48'h0;
          coreOvf[gi] <= 1'b0;
        end else begin
          if (coreEnable[gi]) begin
            coreCount[gi*`PECU_CNT_W +: `PECU_CNT_W] <= sum[`PECU_CNT_W-1:0];
          end
          // Set wins over clear
          coreOvf[gi] <= (coreEnable[gi] & sum[`PECU_CNT_W])
                         | (coreOvf[gi] & ~coreOvfClr[gi]);
        end
      end
    end
  endgenerate

  // ==========================================================================
  // Uncore counters; no core identity enters the count
  generate
    for (gi = 0; gi < `PECU_UNC_CNT; gi = gi + 1) begin : gUnc
      wire [`PECU_EVT_W-1:0]   code;
      wire [`PECU_EVT_W-1:0]   umask;
      wire [`PECU_CMASK_W-1:0] cm;
      // Counter index as a sized constant for the slot compare
      localparam [2:0]         slotIdx = gi;
      reg  [7:0]               inc;
      wire [`PECU_CNT_W:0]     sum;
      wire                     rtAtLevel;
      wire                     rtStageHit;
      wire                     genericHit;
      wire                     slotHit;
      assign code  = uncEvtCode[gi*`PECU_EVT_W +: `PECU_EVT_W];
      assign umask = uncUnitMask[gi*`PECU_EVT_W +: `PECU_EVT_W];
      assign cm    = uncCmask[gi*`PECU_CMASK_W +: `PECU_CMASK_W];

      // Threshold and stage qualify the occupancy
      assign rtAtLevel  = ({2'b00, rtOccupancy} >= cm);
      assign rtStageHit = |(umask[3:0] & rtStageValid);

      // Generic events land on the counter whose slot the code names
      assign genericHit = |(umask & uncEventBits);
      assign slotHit    = (code[2:0] == slotIdx);

      always @* begin
        inc = 8'h00;
        if (code == `PECU_EV_RT_OCC) begin
          if (cm == 8'h00) begin
            inc = {2'b00, rtOccupancy};
          end else begin
            inc = {7'h00, rtAtLevel & rtStageHit};
          end
        end else begin
          inc = {7'h00, genericHit & slotHit};
        end
      end

      assign sum = {1'b0, uncCount[gi*`PECU_CNT_W +: `PECU_CNT_W]} + {41'h0, inc};

      always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
          uncCount[gi*`PECU_CNT_W +: `PECU_CNT_W] <= 48'h0;
          uncOvf[gi] <= 1'b0;
        end else begin
          if (uncEnable[gi]) begin
            uncCount[gi*`PECU_CNT_W +: `PECU_CNT_W] <= sum[`PECU_CNT_W-1:0];
          end
          // Set wins over clear
          uncOvf[gi] <= (uncEnable[gi] & sum[`PECU_CNT_W])
                        | (uncOvf[gi] & ~uncOvfClr[gi]);
        end
      end
    end
  endgenerate

  // ==========================================================================
  // Fixed uncore counter
  wire [`PECU_CNT_W:0] fixedSum;
  wire                 fixedTick;

  // Unhalted level is sampled per cycle; no event code applies here
  assign fixedTick = fixedEnable & uncoreUnhalted;
  assign fixedSum  = {1'b0, fixedCount} + 49'h1;

  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      fixedCount <= 48'h0;
      uncOvf[`PECU_UNC_CNT] <= 1'b0;
    end else begin
      if (fixedTick) begin
        fixedCount <= fixedSum[`PECU_CNT_W-1:0];
      end
      // Set wins over clear
      uncOvf[`PECU_UNC_CNT] <= (fixedTick & fixedSum[`PECU_CNT_W])
                               | (uncOvf[`PECU_UNC_CNT] & ~uncOvfClr[`PECU_UNC_CNT]);
    end
  end

  // ==========================================================================
  // Interrupt requests
  // Core counters route to the logical processor picked per counter.
  reg [`PECU_LP_N-1:0] next_lpPerfIrq;
  integer k;
  always @* begin
    next_lpPerfIrq = {`PECU_LP_N{1'b0}};
    for (k = 0; k < `PECU_CORE_CNT; k = k + 1) begin
      if (coreOvf[k]) begin
        next_lpPerfIrq[coreLpSel[k*3 +: 3]] = 1'b1;
      end
    end
  end

  // Uncore routing ignores which counter wrapped; software reads the flags
  // Requests stay up while any flag is set, one cycle behind it
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      lpPerfIrq   <= 8'h00;
      corePerfIrq <= 4'h0;
    end else begin
      lpPerfIrq   <= next_lpPerfIrq;
      corePerfIrq <= (|uncOvf) ? coreSelPattern : 4'h0;
    end
  end

endmodule

// [test/pecu_irq_sink.sv]
// =====
// Core interrupt hardware model: latches every request it is shown.
// Assumes level requests synchronous to sys_clk.
`timescale 1ns/10ps
module pecu_irq_sink (
  input  wire        sys_clk,
  input  wire        nrst,
  input  wire [7:0]  lpPerfIrq,
  input  wire [3:0]  corePerfIrq,
  output reg  [11:0] taken
);
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst)
      taken <= 12'h000;
    else
      taken <= taken | {corePerfIrq, lpPerfIrq};
  end
endmodule

// [test/pecu_checker.sv]
// =====
// Checker for the counter unit: fixed counting, wrap, request routing.
// Assumes it is bound to pecu_counter_unit.
`timescale 1ns/10ps
`include "pecu_regs.vh"
module pecu_checker (
  input wire                                  sys_clk,
  input wire                                  nrst,
  input wire [`PECU_CORE_CNT*`PECU_EVT_W-1:0] coreEvtCode,
  input wire [`PECU_UNC_CNT:0]                uncOvfClr,
  input wire [`PECU_CORE_N-1:0]               coreSelPattern,
  input wire                                  fixedEnable,
  input wire                                  uncoreUnhalted,
  input wire [`PECU_CORE_CNT*`PECU_CNT_W-1:0] coreCount,
  input wire [`PECU_CNT_W-1:0]                fixedCount,
  input wire [`PECU_CORE_CNT-1:0]             coreOvf,
  input wire [`PECU_UNC_CNT:0]                uncOvf,
  input wire [`PECU_LP_N-1:0]                 lpPerfIrq,
  input wire [`PECU_CORE_N-1:0]               corePerfIrq
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);
  a_fixed_count: assert property (
    (fixedEnable && uncoreUnhalted && !(&fixedCount)) |=> fixedCount == $past(fixedCount) + 1)
    else $error("fixed counter missed a cycle");
  a_fixed_hold: assert property (
    !(fixedEnable && uncoreUnhalted) |=> $stable(fixedCount))
    else $error("fixed counter moved while idle");
  a_fixed_wrap: assert property (
    (fixedEnable && uncoreUnhalted && &fixedCount) |=> fixedCount == 0 && uncOvf[8])
    else $error("fixed counter wrap wrong");
  a_ovf_sticky: assert property (
    (uncOvf[8] && !uncOvfClr[8]) |=> uncOvf[8])
    else $error("overflow flag dropped");
  a_route_pattern: assert property (
    |uncOvf |=> corePerfIrq == $past(coreSelPattern))
    else $error("core request differs from pattern");
  a_route_quiet: assert property (
    uncOvf == 9'h000 |=> corePerfIrq == 4'h0)
    else $error("core request without overflow");
  a_lp_quiet: assert property (
    coreOvf == 4'h0 |=> lpPerfIrq == 8'h00)
    else $error("processor request without overflow");
  a_cache_blocked: assert property (
    coreEvtCode[23:18] == 6'h10 |=> $stable(coreCount[143:96]))
    else $error("cache event counted on counter two");
  c_fixed: cover property (fixedEnable && uncoreUnhalted);
  c_blocked: cover property (coreEvtCode[23:18] == 6'h10);
  c_quiet: cover property (uncOvf == 9'h000 && coreOvf == 4'h0);
endmodule
bind pecu_counter_unit pecu_checker pecu_checker_i (.sys_clk, .nrst, .coreEvtCode,
  .uncOvfClr, .coreSelPattern, .fixedEnable, .uncoreUnhalted, .coreCount,
  .fixedCount, .coreOvf, .uncOvf, .lpPerfIrq, .corePerfIrq);

// [test/tb.sv]
// =====
// Bench for the counter unit: one-cycle events, expected totals.
// Assumes design, checker and interrupt model are compiled first.
`timescale 1ns/10ps
`include "pecu_regs.vh"
module tb;
  reg          sys_clk;
  reg          nrst;
  reg  [7:0]   code, um, cm, loop_stream_detector, ucode, uum, ucm;
  reg  [3:0]   en, st, pat;
  reg  [8:0]   ev;
  reg  [5:0]   rto;
  reg  [11:0]  addr;
  wire [191:0] cc;
  wire [383:0] uc;
  wire [47:0]  fc;
  wire [11:0]  taken;
  wire [7:0]   lirq;
  wire [3:0]   cirq;
  reg  [47:0]  e0, e2, eu, ef;
  integer      n_mismatch, total_checks;
  pecu_counter_unit pecu_counter_unit_i (
    .sys_clk, .nrst, .coreEvtCode({4{code}}), .coreUnitMask({4{um}}), .coreCmask({4{cm}}),
    .coreLpSel(12'h688), .coreEnable(en), .coreOvfClr(4'h0), .dcLoad(ev[8]),
    .dcStore(ev[7]), .dcLock(ev[6]), .dcCacheable(1'b1), .dcState(st), .dcWriteback(ev[5]),
    .l2State(st), .storeFwdCheck(ev[4]), .loadAddrLow(addr), .storeAddrLow(addr),
    .addrFullMatch(ev[3]), .lsdActivity(loop_stream_detector), .complexDecode(ev[2]), .fpAssist(ev[1]),
    .uncEvtCode({8{ucode}}), .uncUnitMask({8{uum}}), .uncCmask({8{ucm}}),
    .uncEnable({2{en}}), .uncOvfClr(9'h000), .coreSelPattern(pat), .fixedEnable(en[0]),
    .uncoreUnhalted(ev[0]), .rtOccupancy(rto), .rtStageValid(st), .uncEventBits(8'h00),
    .coreCount(cc), .uncCount(uc), .fixedCount(fc), .coreOvf(), .uncOvf(),
    .lpPerfIrq(lirq), .corePerfIrq(cirq));
  pecu_irq_sink pecu_irq_sink_i (.sys_clk, .nrst, .lpPerfIrq(lirq), .corePerfIrq(cirq),
    .taken);
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  task chk(input [8*5:1] nm, input [47:0] seen, exp);
    begin
      total_checks = total_checks + 1;
      if (seen !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("[ERR] %0s exp %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task final_report;
    begin
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  task cfg(input [7:0] c, u, m);
    begin
      @(posedge sys_clk);
      code <= c;
      um <= u;
      cm <= m;
    end
  endtask
  // One event cycle, then compare totals of counters 0 and 2, uncore 0 and 7, and fixed
  task fin(input [8:0] v, input [3:0] s, input [7:0] l, input [5:0] r,
           input [47:0] d0, d2, du, df);
    begin
      @(posedge sys_clk);
      ev <= v;
      st <= s;
      loop_stream_detector <= l;
      rto <= r;
      @(posedge sys_clk);
      ev <= 9'h000;
      loop_stream_detector <= 8'h00;
      rto <= 6'h00;
      @(posedge sys_clk);
      #1;
      {e0, e2, eu, ef} = {e0 + d0, e2 + d2, eu + du, ef + df};
      chk("ctr0", cc[47:0], e0);
      chk("ctr2", cc[143:96], e2);
      chk("unc0", uc[47:0], eu);
      chk("unc7", uc[383:336], eu);
      chk("fixed", fc, ef);
    end
  endtask
  initial begin
    {n_mismatch, total_checks, nrst} = 0;
    {code, um, cm, loop_stream_detector, ev, rto, e0, e2, eu, ef} = 0;
    {ucode, uum, ucm, en, st, pat, addr} = {24'h020220, 12'hf05, 12'h5a3};
    repeat (10) @(posedge sys_clk);
    nrst <= 1'b1;
    fin(9'h000, 4'h1, 0, 0, 0, 0, 0, 0);
    cfg(`PECU_EV_DC_LOAD, 8'h01, 8'h00);
    fin(9'h100, 4'h1, 0, 0, 1, 0, 0, 0);
    fin(9'h100, 4'h2, 0, 0, 0, 0, 0, 0);
    cfg(`PECU_EV_DC_STORE, 8'h08, 8'h00);
    fin(9'h080, 4'h8, 0, 0, 1, 0, 0, 0);
    cfg(`PECU_EV_DC_WB, 8'h08, 8'h00);
    fin(9'h020, 4'h8, 0, 0, 1, 0, 0, 0);
    cfg(`PECU_EV_DC_LOCK, 8'h04, 8'h00);
    fin(9'h040, 4'h4, 0, 0, 1, 0, 0, 0);
    cfg(`PECU_EV_ALIAS, `PECU_UM_ALIAS, 8'h00);
    fin(9'h010, 4'h0, 0, 0, 1, 1, 0, 0);
    fin(9'h018, 4'h0, 0, 0, 0, 0, 0, 0);
    cfg(`PECU_EV_LSD, 8'h01, 8'h04);
    fin(9'h000, 4'h0, 5, 0, 1, 1, 0, 0);
    fin(9'h000, 4'h0, 3, 0, 0, 0, 0, 0);
    fin(9'h000, 4'h0, 4, 0, 1, 1, 0, 0);
    cfg(`PECU_EV_MSDEC, 8'h01, 8'h00);
    fin(9'h004, 4'h0, 0, 0, 1, 1, 0, 0);
    fin(9'h002, 4'h0, 0, 0, 1, 1, 0, 0);
    fin(9'h000, 4'h2, 0, 32, 0, 0, 1, 0);
    fin(9'h000, 4'h2, 0, 31, 0, 0, 0, 0);
    @(posedge sys_clk);
    ucm <= 8'h01;
    fin(9'h000, 4'h2, 0, 1, 0, 0, 1, 0);
    fin(9'h001, 4'h0, 0, 0, 0, 0, 0, 1);
    chk("irq", taken, 0);
    final_report;
  end
  initial begin
    #5000;
    n_mismatch = n_mismatch + 1;
    final_report;
  end
endmodule
